// ### mec_consts.svh
// Constants for the memory error and internal fault unit
`ifndef MEC_CONSTS_SVH
`define MEC_CONSTS_SVH
`define MEC_CLK_NS       10
`define MEC_STRETCH_NS   80
`define MEC_STRETCH_CYC  ((`MEC_STRETCH_NS + `MEC_CLK_NS - 1) / `MEC_CLK_NS)
`define MEC_SEL_PEA      3'h0
`define MEC_SEL_PES      3'h1
`define MEC_SEL_ERROR_CORRECTION_CONTROL     3'h2
`define MEC_SEL_IIC      3'h3
`define MEC_SEL_IIE      3'h4
`define MEC_PES_MA       1:0
`define MEC_PES_FETCH    2
`define MEC_PES_DMA      3
`define MEC_PES_BLK      6
`define MEC_PES_OVR      7
`define MEC_PES_ECC      8
`define MEC_PES_SYN      13:9
`define MEC_PES_UB       13
`define MEC_PES_LB       14
`define MEC_ADDR_HI      17:16
`define MEC_ADDR_LO      15:0
`define MEC_CTL_FLOW     0
`define MEC_CTL_FHIGH    1
`define MEC_CTL_ANY      2
`define MEC_CTL_CORRECTION_DISABLE     3
`define MEC_CTL_W        3:0
`define MEC_IIE_W        10:0
`define MEC_IIC_W        3:0
`define MEC_C_MON        1
`define MEC_C_PV         2
`define MEC_C_PF         3
`define MEC_C_II         4
`define MEC_C_Z          5
`define MEC_C_PI         6
`define MEC_C_IOX        7
`define MEC_C_PTY        8
`define MEC_C_MOR        9
`define MEC_C_POW        10
`define MEC_C_TOP        10
`define MEC_DATA_CODES {5'h1b, 5'h19, 5'h18, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, \
  5'h0e, 5'h0d, 5'h0c, 5'h0a, 5'h09, 5'h06, 5'h05, 5'h03}
`endif

// ### mec_pkg.sv
// Types of the memory error and internal fault unit
`default_nettype none
package mec_pkg;
  typedef enum logic [1:0] {MEC_IDLE, MEC_WAIT, MEC_STRETCH} mec_fsm_type;
  typedef struct packed {
    mec_fsm_type fsm;
    logic [15:0] memory_error_address;
    logic [15:0] memory_error_status;
    logic [3:0]  ctrl;
    logic [10:0] internal_cause_enable;
    logic [3:0]  internal_cause_code;
    logic        lvl14;
    logic [15:0] mon;
    logic [15:0] rdata;
    logic [15:0] rfdata;
    logic        done;
    logic        req;
    logic [17:0] addr;
    logic        wr;
    logic        fetch;
    logic        dma;
    logic [15:0] wdata;
    logic [4:0]  wcheck;
    logic [1:0]  wpar;
    logic [3:0]  cnt;
    logic        zprev;
  } mec_state_type;
endpackage : mec_pkg
`default_nettype wire

// ### mec_ecc_if.sv
// Signals between the fault unit and its check code unit
`default_nettype none
interface mec_ecc_if;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [4:0]  rcheck;
  logic [4:0]  wcheck;
  logic [4:0]  syndrome;
  logic [15:0] fixed;
  logic        single;
  logic        multiple;
  modport core  (output wdata, rdata, rcheck, input wcheck, syndrome, fixed, single, multiple);
  modport coder (input wdata, rdata, rcheck, output wcheck, syndrome, fixed, single, multiple);
endinterface : mec_ecc_if
`default_nettype wire

// ### mec_ecc_code.sv
// Check bit generator and syndrome decoder for 21-bit modules
`include "mec_consts.svh"
`default_nettype none
module mec_ecc_code (
  mec_ecc_if.coder ecc
);
  localparam logic [79:0] CODES = `MEC_DATA_CODES;

  function automatic logic [15:0] mec_mask(input int j);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < 16; i++) begin
      m[i] = CODES[5*i+j];
    end
    return m;
  endfunction : mec_mask

  logic [4:0] rcalc;
  for (genvar j = 0; j < 5; j++) begin : g_chk
    assign ecc.wcheck[j] = ^(ecc.wdata & mec_mask(j));
    assign rcalc[j]      = ^(ecc.rdata & mec_mask(j));
  end
  assign ecc.syndrome = rcalc ^ ecc.rcheck;

  // Zero syndrome is good; a data code or a single set bit is correctable
  always_comb begin
    logic hit;
    hit = 1'b0;
    ecc.fixed = ecc.rdata;
    for (int i = 0; i < 16; i++) begin
      if (ecc.syndrome == CODES[5*i+:5]) begin
        ecc.fixed[i] = ~ecc.rdata[i];
        hit = 1'b1;
      end
    end
    ecc.single   = hit || $onehot(ecc.syndrome);
    ecc.multiple = (ecc.syndrome != 5'h00) && !ecc.single;
  end
endmodule : mec_ecc_code
`default_nettype wire

// ### mec_fault_unit.sv
// Memory error capture, check code handling and level-14 internal causes
`include "mec_consts.svh"
`default_nettype none
module mec_fault_unit import mec_pkg::*; (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        mem_ref,
  input  wire logic [17:0] mem_addr,
  input  wire logic        mem_write,
  input  wire logic        mem_fetch,
  input  wire logic        mem_dma,
  input  wire logic [15:0] mem_wdata,
  output logic             ref_done,
  output logic [15:0]      ref_rdata,
  output logic             mm_req,
  output logic [17:0]      mm_addr,
  output logic             mm_write,
  output logic [15:0]      mm_wdata,
  output logic [4:0]       mm_wcheck,
  output logic [1:0]       mm_wpar,
  input  wire logic        mm_ack,
  input  wire logic [15:0] mm_rdata,
  input  wire logic [4:0]  mm_rcheck,
  input  wire logic [1:0]  mm_rpar,
  input  wire logic        mm_wide,
  input  wire logic        mm_nxm,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [2:0]  reg_sel,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  input  wire logic        mon_call,
  input  wire logic [7:0]  mon_call_num,
  input  wire logic        illegal_ref,
  input  wire logic        ring_violation,
  input  wire logic        page_fault,
  input  wire logic        illegal_instr,
  input  wire logic        z_flag,
  input  wire logic        level_entered,
  input  wire logic        priv_instr,
  input  wire logic        iox_no_connect,
  input  wire logic        power_fail,
  output logic [15:0]      mon_call_number,
  output logic             lvl14_req
);
  localparam logic [3:0] STRETCH_LAST = 4'(`MEC_STRETCH_CYC - 1);

  mec_state_type q;
  mec_state_type d;
  mec_ecc_if     ecc ();

  mec_ecc_code u_code (
    .ecc (ecc.coder)
  );

  // Power fail first, otherwise the lowest numbered cause
  function automatic logic [3:0] mec_pick(input logic [10:0] c);
    logic [3:0] k;
    k = '0;
    for (int i = `MEC_C_TOP; i >= 1; i--) begin
      if (c[i]) begin
        k = 4'(i);
      end
    end
    if (c[`MEC_C_POW]) begin
      k = 4'(`MEC_C_POW);
    end
    return k;
  endfunction : mec_pick

  logic [10:0] cause;
  logic [10:0] cause_en;
  logic        ack_now;
  logic        ub_err;
  logic        lb_err;
  logic        ecc_on;
  logic        err18;
  logic        err21;
  logic        mor;
  logic        mem_err;
  logic        corr_single;
  logic        rd_pea;
  logic        rd_iic;
  logic [15:0] next_pes;
  logic [15:0] next_wdata;

  assign ecc.wdata  = mem_wdata;
  assign ecc.rdata  = mm_rdata;
  assign ecc.rcheck = mm_rcheck;

  assign ack_now = (q.fsm == MEC_WAIT) && mm_ack;
  assign ecc_on  = !q.ctrl[`MEC_CTL_CORRECTION_DISABLE];
  // Even parity per byte: data and its parity bit xor to zero
  assign ub_err  = ^{mm_rdata[15:8], mm_rpar[1]};
  assign lb_err  = ^{mm_rdata[7:0], mm_rpar[0]};
  assign mor     = ack_now && mm_nxm;
  // An 18-bit parity error always interrupts unless disabled
  assign err18   = ack_now && !q.wr && !mm_nxm && !mm_wide && (ub_err || lb_err) && ecc_on;
  assign err21   = ack_now && !q.wr && !mm_nxm && mm_wide && ecc_on
                   && (ecc.multiple || (ecc.single && q.ctrl[`MEC_CTL_ANY]));
  assign mem_err = mor || err18 || err21;
  assign corr_single = ack_now && !q.wr && !mm_nxm && mm_wide && ecc_on && ecc.single;
  assign rd_pea  = reg_rd && (reg_sel == `MEC_SEL_PEA);
  assign rd_iic  = reg_rd && (reg_sel == `MEC_SEL_IIC);

  always_comb begin
    cause = '0;
    cause[`MEC_C_MON] = mon_call;
    cause[`MEC_C_PV]  = illegal_ref || ring_violation;
    cause[`MEC_C_PF]  = page_fault;
    cause[`MEC_C_II]  = illegal_instr;
    cause[`MEC_C_Z]   = z_flag && (!q.zprev || level_entered);
    cause[`MEC_C_PI]  = priv_instr;
    cause[`MEC_C_IOX] = iox_no_connect;
    cause[`MEC_C_PTY] = err18 || err21;
    cause[`MEC_C_MOR] = mor;
    cause[`MEC_C_POW] = power_fail;
    cause_en = cause & q.internal_cause_enable;
  end

  // Captured status of a failing reference
  always_comb begin
    next_pes = '0;
    next_pes[`MEC_PES_MA]    = q.addr[`MEC_ADDR_HI];
    next_pes[`MEC_PES_FETCH] = q.fetch;
    next_pes[`MEC_PES_DMA]   = q.dma;
    next_pes[`MEC_PES_BLK]   = 1'b1;
    if (!mm_nxm && mm_wide) begin
      next_pes[`MEC_PES_ECC] = 1'b1;
      next_pes[`MEC_PES_SYN] = ecc.syndrome;
    end else if (!mm_nxm) begin
      next_pes[`MEC_PES_UB] = ub_err;
      next_pes[`MEC_PES_LB] = lb_err;
    end
  end

  // Check bits are computed on true data; test forcing corrupts the stored word
  always_comb begin
    next_wdata = mem_wdata;
    if (q.ctrl[`MEC_CTL_FLOW]) begin
      next_wdata[0] = 1'b1;
    end
    if (q.ctrl[`MEC_CTL_FHIGH]) begin
      next_wdata[15] = 1'b1;
    end
  end

  always_comb begin
    d = q;
    d.req  = 1'b0;
    d.done = 1'b0;
    d.zprev = z_flag;
    case (q.fsm)
      MEC_IDLE: begin
        if (mem_ref) begin
          d.req    = 1'b1;
          d.addr   = mem_addr;
          d.wr     = mem_write;
          d.fetch  = mem_fetch;
          d.dma    = mem_dma;
          d.wdata  = next_wdata;
          d.wcheck = ecc.wcheck;
          d.wpar   = {^mem_wdata[15:8], ^mem_wdata[7:0]};
          d.fsm    = MEC_WAIT;
          if (!q.memory_error_status[`MEC_PES_BLK]) begin
            d.memory_error_address = mem_addr[`MEC_ADDR_LO];
          end
        end
      end
      MEC_WAIT: begin
        if (mm_ack) begin
          d.rfdata = (mm_wide && ecc_on) ? ecc.fixed : mm_rdata;
          if (corr_single) begin
            d.cnt = STRETCH_LAST;
            d.fsm = MEC_STRETCH;
          end else begin
            d.done = 1'b1;
            d.fsm  = MEC_IDLE;
          end
        end
      end
      MEC_STRETCH: begin
        if (q.cnt == 4'h0) begin
          d.done = 1'b1;
          d.fsm  = MEC_IDLE;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      default: begin
        d.fsm = MEC_IDLE;
      end
    endcase

    // A new error in the release cycle keeps the block set
    if (rd_pea) begin
      d.memory_error_status[`MEC_PES_BLK] = 1'b0;
      d.memory_error_status[`MEC_PES_OVR] = 1'b0;
    end
    if (mem_err) begin
      if (q.memory_error_status[`MEC_PES_BLK]) begin
        d.memory_error_status[`MEC_PES_BLK] = 1'b1;
        d.memory_error_status[`MEC_PES_OVR] = 1'b1;
      end else begin
        d.memory_error_status = next_pes;
        d.memory_error_address = q.addr[`MEC_ADDR_LO];
      end
    end

    if (reg_wr) begin
      case (reg_sel)
        `MEC_SEL_ERROR_CORRECTION_CONTROL: d.ctrl = reg_wdata[`MEC_CTL_W];
        `MEC_SEL_IIE:  d.internal_cause_enable  = reg_wdata[`MEC_IIE_W];
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_sel)
        `MEC_SEL_PEA: d.rdata = q.memory_error_address;
        `MEC_SEL_PES: d.rdata = q.memory_error_status;
        `MEC_SEL_IIC: d.rdata = {12'h000, q.internal_cause_code};
        `MEC_SEL_IIE: d.rdata = {5'h00, q.internal_cause_enable};
        default:      d.rdata = 16'h0000;
      endcase
    end

    // A cause arriving with the read is kept
    if (rd_iic) begin
      d.internal_cause_code = 4'h0;
    end
    if (cause_en != 11'h000) begin
      d.internal_cause_code = mec_pick(cause_en);
    end
    d.lvl14 = (d.internal_cause_code != 4'h0);
    if (mon_call) begin
      d.mon = {{8{mon_call_num[7]}}, mon_call_num};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ref_done        = q.done;
  assign ref_rdata       = q.rfdata;
  assign mm_req          = q.req;
  assign mm_addr         = q.addr;
  assign mm_write        = q.wr;
  assign mm_wdata        = q.wdata;
  assign mm_wcheck       = q.wcheck;
  assign mm_wpar         = q.wpar;
  assign reg_rdata       = q.rdata;
  assign mon_call_number = q.mon;
  assign lvl14_req       = q.lvl14;

  AST_MON_SIGN:
    assert property (@(posedge clk) disable iff (!nrst)
      mon_call |=> mon_call_number == {{8{$past(mon_call_num[7])}}, $past(mon_call_num)})
    else $error("monitor call number not sign extended");

  AST_PV_CODE:
    assert property (@(posedge clk) disable iff (!nrst)
      (cause_en == 11'h004) |=> (q.internal_cause_code == 4'h2) && lvl14_req)
    else $error("protect violation code wrong");

  AST_Z_AGAIN:
    assert property (@(posedge clk) disable iff (!nrst)
      (z_flag && level_entered && cause_en == 11'h020) |=> q.internal_cause_code == 4'h5)
    else $error("error indicator not raised on re-entry");

  AST_IOX_CODE:
    assert property (@(posedge clk) disable iff (!nrst)
      (iox_no_connect && q.internal_cause_enable[7] && cause_en[6:0] == 7'h00 && !cause_en[10]) |=> q.internal_cause_code == 4'h7)
    else $error("io error code wrong");

  AST_POW_FIRST:
    assert property (@(posedge clk) disable iff (!nrst)
      (power_fail && q.internal_cause_enable[10]) |=> q.internal_cause_code == 4'ha)
    else $error("power fail lost priority");

  AST_STRETCH:
    assert property (@(posedge clk) disable iff (!nrst)
      corr_single |=> !ref_done [*8] ##1 ref_done)
    else $error("corrected cycle not stretched by 8 clocks");

  AST_PEA_TRACK:
    assert property (@(posedge clk) disable iff (!nrst)
      (q.fsm == MEC_IDLE && mem_ref && !q.memory_error_status[6] && !mem_err) |=> q.memory_error_address == $past(mem_addr[15:0]))
    else $error("error address not tracking");

  AST_FREEZE:
    assert property (@(posedge clk) disable iff (!nrst)
      (q.memory_error_status[6] && !rd_pea) |=> $stable(q.memory_error_address) && $stable(q.memory_error_status[14:8]) && q.memory_error_status[6])
    else $error("blocked error registers changed");

  AST_RELEASE:
    assert property (@(posedge clk) disable iff (!nrst)
      (rd_pea && !mem_err) |=> !q.memory_error_status[6] && reg_rdata == $past(q.memory_error_address))
    else $error("error address read did not release");

  AST_IIC_READ:
    assert property (@(posedge clk) disable iff (!nrst)
      (rd_iic && cause_en == 11'h000) |=> reg_rdata[15:4] == 12'h000 && q.internal_cause_code == 4'h0)
    else $error("cause code read wrong");

  AST_OVERRUN:
    assert property (@(posedge clk) disable iff (!nrst)
      (mem_err && q.memory_error_status[6] && !rd_pea) |=> q.memory_error_status[7] && $stable(q.memory_error_address))
    else $error("overrun not flagged");

  AST_CORRECTION_DISABLE:
    assert property (@(posedge clk) disable iff (!nrst)
      (q.ctrl[3] && ack_now) |=> ref_rdata == $past(mm_rdata))
    else $error("disable did not suppress correction");

  AST_CORRECTION_DISABLE_IRQ:
    assert property (@(posedge clk) disable iff (!nrst)
      q.ctrl[3] |-> !cause[8])
    else $error("disable did not suppress parity interrupt");
endmodule : mec_fault_unit
`default_nettype wire

// ### mec_mem_model.sv
// Behavioural memory with narrow parity and wide check code modules mixed
`default_nettype none
module mec_mem_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        mm_req,
  input  wire logic [17:0] mm_addr,
  input  wire logic        mm_write,
  input  wire logic [15:0] mm_wdata,
  input  wire logic [4:0]  mm_wcheck,
  input  wire logic [1:0]  mm_wpar,
  input  wire logic [3:0]  dly,
  input  wire logic [22:0] flip,
  output logic             mm_ack,
  output logic [15:0]      mm_rdata,
  output logic [4:0]       mm_rcheck,
  output logic [1:0]       mm_rpar,
  output logic             mm_wide,
  output logic             mm_nxm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [22:0] mem [0:31];
  logic [4:0]  idx;
  logic [3:0]  cnt;
  logic        busy;
  logic        nx;
  always_ff @(posedge clk) begin
    mm_ack <= 1'b0;
    if (!nrst) begin
      busy                            <= 1'b0;
      {mm_rpar, mm_rcheck, mm_rdata}  <= 23'h00_0000;
      {mm_wide, mm_nxm}               <= 2'h0;
    end else if (mm_req) begin
      busy <= 1'b1;
      cnt  <= dly;
      idx  <= mm_addr[4:0];
      // Top page of each 64K bank is left unpopulated
      nx   <= mm_addr[15:12] == 4'hf;
      if (mm_write) begin
        mem[mm_addr[4:0]] <= {mm_wpar, mm_wcheck, mm_wdata};
      end
    end else if (busy && cnt == 4'h0) begin
      busy                           <= 1'b0;
      mm_ack                         <= 1'b1;
      {mm_rpar, mm_rcheck, mm_rdata} <= mem[idx] ^ flip;
      mm_wide                        <= idx[4];
      mm_nxm                         <= nx;
    end else begin
      cnt <= cnt - 4'h1;
      // Read data, check and parity lines are not held once the cycle is over
      {mm_rpar, mm_rcheck, mm_rdata} <= ~{mm_rpar, mm_rcheck, mm_rdata};
    end
  end
endmodule : mec_mem_model
`default_nettype wire

// ### test_memory_error_and_internal_faults.sv
// Self-checking bench for the memory error and internal fault unit
`default_nettype none
module test_memory_error_and_internal_faults;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, mem_ref, mem_write, mem_fetch, mem_dma, ref_done, mm_req, mm_write, mm_ack;
  logic        mm_wide, mm_nxm, reg_rd, reg_wr, z_flag, lvl14_req;
  logic [17:0] mem_addr, mm_addr;
  logic [15:0] mem_wdata, ref_rdata, mm_wdata, mm_rdata, reg_wdata, reg_rdata, mon_call_number, v;
  logic [4:0]  mm_wcheck, mm_rcheck;
  logic [1:0]  mm_wpar, mm_rpar;
  logic [2:0]  reg_sel;
  logic [7:0]  mon_call_num;
  logic [10:0] cs;
  logic [3:0]  dly;
  logic [22:0] flip;
  int          err_count, checks, lat, i;

  mec_fault_unit i_dut (.clk, .nrst, .mem_ref, .mem_addr, .mem_write, .mem_fetch, .mem_dma, .mem_wdata,
    .ref_done, .ref_rdata, .mm_req, .mm_addr, .mm_write, .mm_wdata, .mm_wcheck, .mm_wpar, .mm_ack,
    .mm_rdata, .mm_rcheck, .mm_rpar, .mm_wide, .mm_nxm, .reg_rd, .reg_wr, .reg_sel, .reg_wdata,
    .reg_rdata, .mon_call(cs[1]), .mon_call_num, .illegal_ref(cs[2]), .ring_violation(cs[0]),
    .page_fault(cs[3]), .illegal_instr(cs[4]), .z_flag, .level_entered(cs[5]), .priv_instr(cs[6]),
    .iox_no_connect(cs[7]), .power_fail(cs[10]), .mon_call_number, .lvl14_req);
  mec_mem_model i_mem (.clk, .nrst, .mm_req, .mm_addr, .mm_write, .mm_wdata, .mm_wcheck, .mm_wpar,
    .dly, .flip, .mm_ack, .mm_rdata, .mm_rcheck, .mm_rpar, .mm_wide, .mm_nxm);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_sel   = s;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] s);
    @(negedge clk);
    reg_rd  = 1'b1;
    reg_sel = s;
    @(negedge clk);
    reg_rd = 1'b0;
    v      = reg_rdata;
  endtask : rd

  task automatic rdc(input string n, input logic [2:0] s, input logic [15:0] m, input logic [15:0] e);
    rd(s);
    chk(n, e, v & m);
  endtask : rdc

  // Latency is counted from the memory answer to the finish pulse
  task automatic mref(input logic [17:0] a, input logic w, input logic f, input logic d,
                      input logic [15:0] wd);
    int n;
    int ak;
    @(negedge clk);
    mem_ref   = 1'b1;
    mem_addr  = a;
    mem_write = w;
    mem_fetch = f;
    mem_dma   = d;
    mem_wdata = wd;
    @(negedge clk);
    mem_ref = 1'b0;
    ak      = 0;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (mm_ack === 1'b1) ak = n;
      if (ref_done === 1'b1) break;
    end
    if (n == 40) begin
      err_count++;
      tally_and_finish();
    end
    lat = n - ak;
  endtask : mref

  task automatic pulse(input int k);
    @(negedge clk);
    cs[k] = 1'b1;
    @(negedge clk);
    cs = 11'h000;
  endtask : pulse

  task automatic cause(input logic [15:0] code);
    chk("lvl14_req", 16'h0001, {15'h0000, lvl14_req});
    rd(3'h3);
    chk("cause_code", code, v);
    chk("lvl14_clear", 16'h0000, {15'h0000, lvl14_req});
  endtask : cause

  initial begin
    {nrst, mem_ref, mem_write, mem_fetch, mem_dma, reg_rd, reg_wr, z_flag} = 8'h00;
    {mem_addr, mem_wdata, reg_sel, reg_wdata, mon_call_num, cs} = 72'h00_0000_0000_0000_0000;
    dly       = 4'h0;
    flip      = 23'h00_0000;
    err_count = 0;
    checks    = 0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    for (i = 0; i < 6; i++) rdc("reset_value", i[2:0], 16'hffff, 16'h0000);
    wr(3'h4, 16'h07fe);
    rdc("enable", 3'h4, 16'hffff, 16'h07fe);
    mref(18'h0_0001, 1'b1, 1'b0, 1'b0, 16'ha5c3);
    mref(18'h0_0011, 1'b1, 1'b0, 1'b0, 16'h3c5a);
    mref(18'h0_0001, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk("narrow_read", 16'ha5c3, ref_rdata);
    dly = 4'h4;
    mref(18'h0_0011, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk("wide_read", 16'h3c5a, ref_rdata);
    rdc("addr_track", 3'h0, 16'hffff, 16'h0011);
    flip = 23'h00_0001;
    mref(18'h0_0011, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk("corrected", 16'h3c5a, ref_rdata);
    chk("stretch", 16'h0009, lat[15:0]);
    chk("silent", 16'h0000, {15'h0000, lvl14_req});
    rdc("no_block", 3'h1, 16'h00c0, 16'h0000);
    flip = 23'h00_0000;
    wr(3'h2, 16'h0004);
    mref(18'h1_0013, 1'b1, 1'b0, 1'b0, 16'h1234);
    mref(18'h0_0014, 1'b1, 1'b0, 1'b0, 16'h5555);
    flip = 23'h01_0000;
    mref(18'h1_0013, 1'b0, 1'b1, 1'b0, 16'h0000);
    chk("corr_any", 16'h1234, ref_rdata);
    cause(16'h0008);
    rdc("status", 3'h1, 16'hffff, 16'h0345);
    mref(18'h0_0014, 1'b0, 1'b0, 1'b1, 16'h0000);
    rdc("status_ovr", 3'h1, 16'hffff, 16'h03c5);
    rdc("addr_frozen", 3'h0, 16'hffff, 16'h0013);
    rdc("released", 3'h1, 16'h00c0, 16'h0000);
    rd(3'h3);
    wr(3'h2, 16'h0000);
    // Data bits 0 and 1 alias to the code of data bit 2; data bit 0 with check bit 2 is a true multiple
    flip = 23'h04_0001;
    mref(18'h0_0014, 1'b0, 1'b0, 1'b0, 16'h0000);
    cause(16'h0008);
    rdc("multi", 3'h1, 16'hffff, 16'h0f40);
    rdc("multi_addr", 3'h0, 16'hffff, 16'h0014);
    flip = 23'h00_0000;
    mref(18'h3_0002, 1'b1, 1'b0, 1'b0, 16'hf00f);
    flip = 23'h00_8000;
    mref(18'h3_0002, 1'b0, 1'b0, 1'b1, 16'h0000);
    cause(16'h0008);
    rdc("parity", 3'h1, 16'he1ff, 16'h204b);
    rdc("par_addr", 3'h0, 16'hffff, 16'h0002);
    wr(3'h2, 16'h0008);
    flip = 23'h00_0001;
    mref(18'h0_0011, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk("disabled", 16'h3c5b, ref_rdata);
    chk("no_irq", 16'h0000, {15'h0000, lvl14_req});
    rd(3'h0);
    flip = 23'h00_0000;
    mref(18'h2_f0a1, 1'b0, 1'b0, 1'b0, 16'h0000);
    cause(16'h0009);
    rdc("nxm_status", 3'h1, 16'h00c3, 16'h0042);
    rdc("nxm_addr", 3'h0, 16'hffff, 16'hf0a1);
    wr(3'h2, 16'h0003);
    mref(18'h0_0003, 1'b1, 1'b0, 1'b0, 16'h0000);
    chk("forced", 16'h8001, mm_wdata);
    wr(3'h2, 16'h0000);
    mon_call_num = 8'h80;
    for (i = 0; i < 8; i++) begin
      if (i != 5) begin
        pulse(i);
        cause(i == 0 ? 16'h0002 : i[15:0]);
      end
    end
    chk("mon_num", 16'hff80, mon_call_number);
    z_flag = 1'b1;
    @(negedge clk);
    cause(16'h0005);
    pulse(5);
    cause(16'h0005);
    z_flag = 1'b0;
    @(negedge clk);
    cs[3]  = 1'b1;
    cs[10] = 1'b1;
    @(negedge clk);
    cs = 11'h000;
    cause(16'h000a);
    wr(3'h4, 16'h0000);
    pulse(3);
    chk("masked", 16'h0000, {15'h0000, lvl14_req});
    tally_and_finish();
  end
endmodule : test_memory_error_and_internal_faults
`default_nettype wire
